// ===== rtl/sar_adc_pkg.sv
// Package with register map, field layout, reset values and state of the SAR converter sequencer.
package sar_adc_pkg;

  // Byte address of a register is four times its index.
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_MODE = 8'hd2;
  localparam logic [7:0] IDX_RES_HI = 8'hd3;
  localparam logic [7:0] IDX_RES_LO = 8'hd4;
  localparam logic [7:0] IDX_REF = 8'hd5;
  localparam logic [7:0] IDX_PORT1 = 8'h9f;
  localparam logic [7:0] IDX_PORT2 = 8'hd6;
  localparam logic [7:0] IDX_PORT3 = 8'hd7;
  localparam logic [7:0] IDX_IRQ_STAT = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'he1;

  // Mode register fields.
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_START_BIT = 6;
  localparam int MODE_EOC_BIT = 5;
  localparam int MODE_SRC_BIT = 4;
  localparam int MODE_CHS_LSB = 0;

  // Result low and clock register fields.
  localparam int LO_GLOBAL_CHANNEL_ENABLE_BIT = 6;
  localparam int LO_DIV_LSB = 4;
  localparam int LO_RES_LSB = 0;

  // Reference register fields.
  localparam int REF_EXT_BIT = 7;
  localparam int REF_PWM_BIT = 4;
  localparam int REF_VHS_LSB = 0;

  // Interrupt status and mask layout.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_W = 1;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CHS = 4'h0;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic [2:0] RST_VHS = 3'h0;
  localparam logic [1:0] RST_PORT3 = 2'h0;
  localparam logic [11:0] RST_RESULT = 12'h000;

  // Clock rate codes and the source divide ratio of each.
  localparam logic [1:0] DIV_CODE_16 = 2'h0;
  localparam logic [1:0] DIV_CODE_8 = 2'h1;
  localparam logic [1:0] DIV_CODE_1 = 2'h2;
  localparam logic [1:0] DIV_CODE_2 = 2'h3;
  localparam int DIV_RATIO_16 = 16;
  localparam int DIV_RATIO_8 = 8;
  localparam int DIV_RATIO_1 = 1;
  localparam int DIV_RATIO_2 = 2;

  // Conversion length: periods of the divided clock, each of this many divided ticks.
  localparam int CONV_PERIODS = 16;
  localparam int CONV_QUARTER = 4;

  // Channel codes.
  localparam int NUM_EXT = 13;
  localparam logic [3:0] CHS_RESERVED = 4'hd;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

  typedef struct packed {
    conv_state_t state;
    logic enable;
    logic eoc;
    logic src_sel;
    logic [3:0] chs;
    logic [11:0] result;
    logic global_channel_enable;
    logic [1:0] div;
    logic ext_ref;
    logic pwm_trig;
    logic [2:0] vhs;
    logic [7:0] port1;
    logic [7:0] port2;
    logic [1:0] port3;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [3:0] pre_cnt;
    logic [1:0] qtr_cnt;
    logic [3:0] per_cnt;
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic [NUM_EXT-1:0] route;
    logic internal_sel;
  } adc_state_t;

endpackage

// ===== rtl/sar_adc_sequencer.sv
// Register file, conversion timer and result capture of the 12-bit SAR converter.
//
// Behaviour
// [RULE1] Conversion lasts sixteen periods of the divided clock divided by four.
// [RULE2] Mode bit 4 picks main oscillator at 0, low-speed oscillator at 1.
// [RULE3] Rate code 00 divides by 16, 01 by 8, 10 by 1, 11 by 2.
// [RULE4] Result bits 11..4 in high register, bits 3..0 in low nibble of second.
// [RULE5] Result registers are read-only; writes leave them unchanged.
// [RULE6] Result is the unsigned binary fraction n of 4096 of the high reference.
// [RULE7] Mode bit 7 enables the converter, resets to 0, software clears before stop.
// [RULE8] Writing 1 to start bit 6 begins conversion; hardware clears it at finish.
// [RULE9] End flag bit 5 is 0 while converting, set at finish, cleared by firmware.
// [RULE10] Channel codes 0..12 route external inputs, 13 reserved, others internal level.
// [RULE11] Software keeps the high reference off internal levels when internal channel used.
// [RULE12] Completion sets end flag, request flag and result; interrupt entry clears request.
// [RULE13] With PWM trigger enabled, conversions repeat while the PWM stays enabled.
// [RULE14] Global channel enable must be 1 to connect the chosen channel.
// [RULE15] External reference enable picks the pin, else the internal select field.
// [RULE16] Both result registers update in the cycle the end flag is set.
// [RULE17] Start while disabled or busy neither restarts nor corrupts a conversion.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sar_adc_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [sar_adc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic osc_tick,
  input wire logic losc_tick,
  input wire logic pwm_enable,
  input wire logic [11:0] sar_code,
  input wire logic irq_ack,
  output logic irq,
  output logic converter_power,
  output logic sar_sample,
  output logic [sar_adc_pkg::NUM_EXT-1:0] ext_channel_sel,
  output logic internal_level_channel,
  output logic external_reference_enable,
  output logic [2:0] internal_reference_select,
  output logic [7:0] port1_analog_only,
  output logic [7:0] port2_analog_only,
  output logic [1:0] port3_analog_only
);

  localparam logic [1:0] QTR_LAST = 2'(sar_adc_pkg::CONV_QUARTER - 1);
  localparam logic [3:0] PER_LAST = 4'(sar_adc_pkg::CONV_PERIODS - 1);
  localparam int IRQ_W_M1 = sar_adc_pkg::IRQ_W - 1;

  sar_adc_pkg::adc_state_t s_q;
  sar_adc_pkg::adc_state_t s_d;

  // Last prescaler count for each rate code; the prescaler wraps there.
  function automatic logic [3:0] div_last(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      sar_adc_pkg::DIV_CODE_16: r = 4'(sar_adc_pkg::DIV_RATIO_16 - 1); // [RULE3]
      sar_adc_pkg::DIV_CODE_8: r = 4'(sar_adc_pkg::DIV_RATIO_8 - 1); // [RULE3]
      sar_adc_pkg::DIV_CODE_1: r = 4'(sar_adc_pkg::DIV_RATIO_1 - 1); // [RULE3]
      sar_adc_pkg::DIV_CODE_2: r = 4'(sar_adc_pkg::DIV_RATIO_2 - 1); // [RULE3]
    endcase
    return r;
  endfunction

  // One-hot external input select; nothing is connected without the global enable.
  function automatic logic [sar_adc_pkg::NUM_EXT-1:0] ext_route(input logic [3:0] chs, input logic on);
    logic [sar_adc_pkg::NUM_EXT-1:0] r;
    r = '0;
    for (int i = 0; i < sar_adc_pkg::NUM_EXT; i++) begin
      r[i] = on && (chs == 4'(i)); // [RULE10] [RULE14]
    end
    return r;
  endfunction

  // Codes above the reserved one select the internal level channel.
  function automatic logic is_internal(input logic [3:0] chs);
    return chs > sar_adc_pkg::CHS_RESERVED; // [RULE10]
  endfunction

  // Read view of every mapped register; reserved bits and unmapped indices read zero.
  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input sar_adc_pkg::adc_state_t s);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      sar_adc_pkg::IDX_MODE: begin
        b[sar_adc_pkg::MODE_EN_BIT] = s.enable;
        b[sar_adc_pkg::MODE_START_BIT] = (s.state == sar_adc_pkg::ST_CONVERT); // [RULE8]
        b[sar_adc_pkg::MODE_EOC_BIT] = s.eoc; // [RULE9]
        b[sar_adc_pkg::MODE_SRC_BIT] = s.src_sel;
        b[sar_adc_pkg::MODE_CHS_LSB +: 4] = s.chs;
      end
      sar_adc_pkg::IDX_RES_HI: b = s.result[11:4]; // [RULE4]
      sar_adc_pkg::IDX_RES_LO: begin
        b[sar_adc_pkg::LO_GLOBAL_CHANNEL_ENABLE_BIT] = s.global_channel_enable;
        b[sar_adc_pkg::LO_DIV_LSB +: 2] = s.div;
        b[sar_adc_pkg::LO_RES_LSB +: 4] = s.result[3:0]; // [RULE4]
      end
      sar_adc_pkg::IDX_REF: begin
        b[sar_adc_pkg::REF_EXT_BIT] = s.ext_ref;
        b[sar_adc_pkg::REF_PWM_BIT] = s.pwm_trig;
        b[sar_adc_pkg::REF_VHS_LSB +: 3] = s.vhs;
      end
      sar_adc_pkg::IDX_PORT1: b = s.port1;
      sar_adc_pkg::IDX_PORT2: b = s.port2;
      sar_adc_pkg::IDX_PORT3: b[1:0] = s.port3;
      sar_adc_pkg::IDX_IRQ_STAT: b[IRQ_W_M1:0] = s.irq_stat;
      sar_adc_pkg::IDX_IRQ_MASK: b[IRQ_W_M1:0] = s.irq_mask;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb begin
    logic [7:0] idx;
    logic [7:0] wd;
    logic req;
    logic wr;
    logic start_req;
    logic src_tick;
    logic done;
    logic stat_clr;
    idx = avs_address[9:2];
    wd = avs_writedata[7:0];
    req = (avs_read || avs_write) && !s_q.ack;
    wr = req && avs_write && avs_byteenable[0];
    start_req = 1'b0;
    src_tick = 1'b0;
    done = 1'b0;
    stat_clr = 1'b0;
    s_d = s_q;

    // Every request is answered one cycle after it is seen; the ack flop keeps a
    // held request from being taken twice while the master releases it.
    s_d.ack = req;
    s_d.waitreq = !req;
    if (req && avs_read) begin
      s_d.rdata = {24'h000000, rd_byte(idx, s_q)};
      stat_clr = (idx == sar_adc_pkg::IDX_IRQ_STAT);
    end

    if (wr) begin
      unique case (idx)
        sar_adc_pkg::IDX_MODE: begin
          s_d.enable = wd[sar_adc_pkg::MODE_EN_BIT]; // [RULE7]
          s_d.eoc = wd[sar_adc_pkg::MODE_EOC_BIT]; // [RULE9]
          s_d.src_sel = wd[sar_adc_pkg::MODE_SRC_BIT];
          s_d.chs = wd[sar_adc_pkg::MODE_CHS_LSB +: 4];
          start_req = wd[sar_adc_pkg::MODE_START_BIT]; // [RULE8]
        end
        sar_adc_pkg::IDX_RES_LO: begin
          // The result nibble in this register is not writable.
          s_d.global_channel_enable = wd[sar_adc_pkg::LO_GLOBAL_CHANNEL_ENABLE_BIT]; // [RULE14]
          s_d.div = wd[sar_adc_pkg::LO_DIV_LSB +: 2]; // [RULE3]
        end
        sar_adc_pkg::IDX_REF: begin
          s_d.ext_ref = wd[sar_adc_pkg::REF_EXT_BIT]; // [RULE15]
          s_d.pwm_trig = wd[sar_adc_pkg::REF_PWM_BIT]; // [RULE13]
          s_d.vhs = wd[sar_adc_pkg::REF_VHS_LSB +: 3]; // [RULE15]
        end
        sar_adc_pkg::IDX_PORT1: s_d.port1 = wd;
        sar_adc_pkg::IDX_PORT2: s_d.port2 = wd;
        sar_adc_pkg::IDX_PORT3: s_d.port3 = wd[1:0];
        sar_adc_pkg::IDX_IRQ_MASK: s_d.irq_mask = wd[IRQ_W_M1:0];
        default: s_d.rdata = s_q.rdata; // [RULE5]
      endcase
    end

    // Clearing the enable abandons a running conversion; no result is produced.
    if (!s_d.enable) begin
      s_d.state = sar_adc_pkg::ST_IDLE; // [RULE7]
    end

    // A start is only taken when enabled and idle, so a second write of the start
    // bit cannot reset the timer of a conversion already under way.
    if (s_d.enable && s_q.state == sar_adc_pkg::ST_IDLE &&
        (start_req || (s_d.pwm_trig && pwm_enable))) begin // [RULE17] [RULE13]
      s_d.state = sar_adc_pkg::ST_CONVERT; // [RULE8]
      s_d.eoc = 1'b0; // [RULE9]
      s_d.pre_cnt = 4'h0;
      s_d.qtr_cnt = 2'h0;
      s_d.per_cnt = 4'h0;
    end

    // The converter clock is the chosen oscillator tick, divided by the rate code,
    // then by four; sixteen such periods make one conversion.
    src_tick = s_q.src_sel ? losc_tick : osc_tick; // [RULE2]
    if (s_q.state == sar_adc_pkg::ST_CONVERT && s_d.state == sar_adc_pkg::ST_CONVERT && src_tick) begin
      if (s_q.pre_cnt >= div_last(s_q.div)) begin // [RULE3]
        s_d.pre_cnt = 4'h0;
        s_d.qtr_cnt = s_q.qtr_cnt + 2'h1;
        if (s_q.qtr_cnt == QTR_LAST) begin // [RULE1]
          s_d.qtr_cnt = 2'h0;
          s_d.per_cnt = s_q.per_cnt + 4'h1;
          done = (s_q.per_cnt == PER_LAST); // [RULE1]
        end
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 4'h1;
      end
    end

    // Completion: both result bytes and the end flag change on the same edge, and
    // the hardware set overrides a software clear of the flag in that cycle.
    if (done) begin
      s_d.state = sar_adc_pkg::ST_IDLE; // [RULE8]
      s_d.result = sar_code; // [RULE6] [RULE16] [RULE12]
      s_d.eoc = 1'b1; // [RULE9] [RULE12]
      s_d.per_cnt = 4'h0;
    end

    // Request flag: cleared by a status read or by interrupt entry, set wins.
    if (stat_clr) begin
      s_d.irq_stat = '0;
    end
    if (irq_ack) begin
      s_d.irq_stat[sar_adc_pkg::IRQ_DONE_BIT] = 1'b0; // [RULE12]
    end
    if (done) begin
      s_d.irq_stat[sar_adc_pkg::IRQ_DONE_BIT] = 1'b1; // [RULE12]
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask); // [RULE12]

    // Analog routing follows the registered configuration.
    s_d.route = ext_route(s_d.chs, s_d.global_channel_enable); // [RULE10] [RULE14]
    s_d.internal_sel = s_d.global_channel_enable && is_internal(s_d.chs); // [RULE10] [RULE14]
  end

  // The result is cleared at reset only for determinism; software must treat it as
  // meaningless until the end flag is first set.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.state <= sar_adc_pkg::ST_IDLE;
      s_q.enable <= 1'b0; // [RULE7]
      s_q.eoc <= 1'b0;
      s_q.src_sel <= 1'b0;
      s_q.chs <= sar_adc_pkg::RST_CHS;
      s_q.result <= sar_adc_pkg::RST_RESULT; // [RULE5]
      s_q.global_channel_enable <= 1'b0;
      s_q.div <= sar_adc_pkg::RST_DIV;
      s_q.ext_ref <= 1'b0;
      s_q.pwm_trig <= 1'b0;
      s_q.vhs <= sar_adc_pkg::RST_VHS;
      s_q.port1 <= sar_adc_pkg::RST_BYTE;
      s_q.port2 <= sar_adc_pkg::RST_BYTE;
      s_q.port3 <= sar_adc_pkg::RST_PORT3;
      s_q.irq_stat <= '0;
      s_q.irq_mask <= '0;
      s_q.irq <= 1'b0;
      s_q.pre_cnt <= 4'h0;
      s_q.qtr_cnt <= 2'h0;
      s_q.per_cnt <= 4'h0;
      s_q.ack <= 1'b0;
      s_q.waitreq <= 1'b1;
      s_q.rdata <= 32'h00000000;
      s_q.route <= '0;
      s_q.internal_sel <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign irq = s_q.irq;
  assign converter_power = s_q.enable; // [RULE7]
  assign sar_sample = (s_q.state == sar_adc_pkg::ST_CONVERT);
  assign ext_channel_sel = s_q.route;
  assign internal_level_channel = s_q.internal_sel;
  assign external_reference_enable = s_q.ext_ref; // [RULE15]
  assign internal_reference_select = s_q.vhs; // [RULE15]
  assign port1_analog_only = s_q.port1;
  assign port2_analog_only = s_q.port2;
  assign port3_analog_only = s_q.port3;

endmodule

// ===== verification/sar_analog_model.sv
// Model of the analog core and the two oscillator tick sources.
`timescale 1ns/1ps
module sar_analog_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sample,
  input wire logic [11:0] level,
  output logic osc_tick,
  output logic losc_tick,
  output logic [11:0] sar_code
);
  logic [1:0] div_q;
  always_ff @(posedge ref_clk) begin
    div_q <= rst ? 2'h0 : div_q + 2'h1;
  end
  assign osc_tick = div_q[0];
  assign losc_tick = div_q == 2'h3;
  // Outside a sample the code is not valid, so it shows the inverse to expose a late capture.
  assign sar_code = sample ? level : ~level;
endmodule

// ===== verification/sar_adc_sequencer_properties.sv
// Concurrent checks on the ports of the converter sequencer.
`timescale 1ns/1ps
module sar_adc_sequencer_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic irq_ack,
  input wire logic converter_power,
  input wire logic sar_sample,
  input wire logic [sar_adc_pkg::NUM_EXT-1:0] ext_channel_sel,
  input wire logic internal_level_channel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_one_answer;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("waitrequest low twice");
  property p_answer_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without request");
  // A conversion that ends with the converter still powered is a completion, not an abort.
  property p_min_conv;
    $fell(sar_sample) && converter_power |-> $past(sar_sample, 8);
  endproperty
  a_min_conv: assert property (p_min_conv) else $error("conversion too short");
  property p_needs_power;
    sar_sample |-> converter_power;
  endproperty
  a_needs_power: assert property (p_needs_power) else $error("converting while disabled");
  property p_one_channel;
    $onehot0(ext_channel_sel);
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("two inputs routed");
  property p_internal_alone;
    internal_level_channel |-> ext_channel_sel == 13'h0;
  endproperty
  a_internal_alone: assert property (p_internal_alone) else $error("internal with external");
  property p_irq_cause;
    $rose(irq) |-> $fell(sar_sample) || $past(avs_write);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_ack_clears;
    irq_ack && !sar_sample |=> !irq;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("irq stays after entry");
  property p_power_write;
    $changed(converter_power) |-> $past(avs_write) || $past(rst);
  endproperty
  a_power_write: assert property (p_power_write) else $error("enable moved alone");
endmodule

bind sar_adc_sequencer sar_adc_sequencer_properties u_props (
  .ref_clk(ref_clk),
  .rst(rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq),
  .irq_ack(irq_ack),
  .converter_power(converter_power),
  .sar_sample(sar_sample),
  .ext_channel_sel(ext_channel_sel),
  .internal_level_channel(internal_level_channel)
);

// ===== verification/sar_adc_sequencer_tb.sv
// Register-level testbench of the converter sequencer.
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [sar_adc_pkg::ADDR_W-1:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic pwm_enable = 1'b0;
  logic irq_ack = 1'b0;
  logic clk_en = 1'b1;
  logic src = 1'b0;
  logic [11:0] level = 12'h000;
  logic [31:0] avs_readdata;
  logic [11:0] sar_code;
  logic [12:0] ext_channel_sel;
  logic [7:0] p1, p2;
  logic [2:0] vhs;
  logic [1:0] p3;
  logic avs_waitrequest, osc_tick, losc_tick, irq, converter_power, sar_sample, internal_level_channel, ext_ref;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int ticks = 0;

  sar_analog_model u_core (.ref_clk(ref_clk), .rst(rst), .sample(sar_sample), .level(level),
    .osc_tick(osc_tick), .losc_tick(losc_tick), .sar_code(sar_code));
  sar_adc_sequencer u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_tick(osc_tick), .losc_tick(losc_tick), .pwm_enable(pwm_enable), .sar_code(sar_code),
    .irq_ack(irq_ack), .irq(irq), .converter_power(converter_power), .sar_sample(sar_sample),
    .ext_channel_sel(ext_channel_sel), .internal_level_channel(internal_level_channel),
    .external_reference_enable(ext_ref), .internal_reference_select(vhs), .port1_analog_only(p1),
    .port2_analog_only(p2), .port3_analog_only(p3));

  always #2.5 ref_clk = ~ref_clk;

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Ticks of the selected source are counted here so the length does not depend on tick spacing.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (clk_en && sar_sample === 1'b1 && (src ? losc_tick : osc_tick)) begin
      ticks <= ticks + 1;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= is_wr;
    avs_read <= !is_wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) n_mismatch++;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wait_s(input logic v);
    int n;
    n = 0;
    while (sar_sample !== v && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000) n_mismatch++;
  endtask

  task automatic conv(input logic s, input logic [1:0] dv, input logic [11:0] lv);
    int e;
    int t0;
    e = dv == 2'h0 ? 16 : dv == 2'h1 ? 8 : dv == 2'h2 ? 1 : 2;
    e = e * sar_adc_pkg::CONV_PERIODS * sar_adc_pkg::CONV_QUARTER;
    t0 = ticks;
    level <= lv;
    src <= s;
    wr(sar_adc_pkg::IDX_RES_LO, {2'b01, dv, 4'h0});
    wr(sar_adc_pkg::IDX_MODE, {3'b110, s, 4'h5});
    rd(sar_adc_pkg::IDX_MODE, {3'b110, s, 4'h5});
    wr(sar_adc_pkg::IDX_MODE, {3'b110, s, 4'h5});
    // A frozen clock enable must hold the timer; ticks seen while frozen do not count.
    clk_en <= 1'b0;
    repeat (7) @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_s(1'b0);
    @(posedge ref_clk);
    chk(ticks - t0, e);
    rd(sar_adc_pkg::IDX_MODE, {3'b101, s, 4'h5});
    rd(sar_adc_pkg::IDX_RES_HI, lv[11:4]);
    rd(sar_adc_pkg::IDX_RES_LO, {2'b01, dv, lv[3:0]});
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(sar_adc_pkg::IDX_MODE, 8'h00);
    wr(sar_adc_pkg::IDX_REF, 8'hff);
    rd(sar_adc_pkg::IDX_REF, 8'h97);
    chk({ext_ref, vhs}, 4'hf);
    // The high reference sits on the supply before the internal level channel is ever routed.
    wr(sar_adc_pkg::IDX_REF, 8'h03);
    chk({ext_ref, vhs}, 4'h3);
    wr(sar_adc_pkg::IDX_RES_HI, 8'hff);
    rd(sar_adc_pkg::IDX_RES_HI, 8'h00);
    avs_byteenable <= 4'he;
    wr(sar_adc_pkg::IDX_PORT1, 8'ha5);
    avs_byteenable <= 4'hf;
    rd(sar_adc_pkg::IDX_PORT1, 8'h00);
    rd(8'h00, 8'h00);
    wr(sar_adc_pkg::IDX_PORT1, 8'h3c);
    wr(sar_adc_pkg::IDX_PORT2, 8'hc3);
    wr(sar_adc_pkg::IDX_PORT3, 8'hff);
    rd(sar_adc_pkg::IDX_PORT3, 8'h03);
    chk({p1, p2, p3}, {8'h3c, 8'hc3, 2'h3});
    for (int c = 0; c < 16; c++) begin
      wr(sar_adc_pkg::IDX_RES_LO, 8'h40);
      wr(sar_adc_pkg::IDX_MODE, c[7:0]);
      @(posedge ref_clk);
      chk(ext_channel_sel, c < 13 ? 13'h1 << c : 13'h0);
      chk(internal_level_channel, c > 13);
      wr(sar_adc_pkg::IDX_RES_LO, 8'h00);
      @(posedge ref_clk);
      chk({internal_level_channel, ext_channel_sel}, 14'h0);
    end
    wr(sar_adc_pkg::IDX_MODE, 8'h40);
    repeat (3) @(posedge ref_clk);
    chk(sar_sample, 1'b0);
    wr(sar_adc_pkg::IDX_IRQ_MASK, 8'h01);
    conv(1'b0, 2'h0, 12'h000);
    chk(irq, 1'b1);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(sar_adc_pkg::IDX_IRQ_MASK, 8'h00);
    conv(1'b0, 2'h1, 12'hfff);
    chk(irq, 1'b0);
    wr(sar_adc_pkg::IDX_IRQ_MASK, 8'h01);
    @(posedge ref_clk);
    chk(irq, 1'b1);
    rd(sar_adc_pkg::IDX_IRQ_STAT, 8'h01);
    rd(sar_adc_pkg::IDX_IRQ_STAT, 8'h00);
    chk(irq, 1'b0);
    conv(1'b0, 2'h2, 12'h5a3);
    conv(1'b0, 2'h3, 12'hc71);
    wr(sar_adc_pkg::IDX_RES_LO, 8'h7f);
    rd(sar_adc_pkg::IDX_RES_LO, 8'h71);
    conv(1'b1, 2'h2, 12'h3c6);
    wr(sar_adc_pkg::IDX_MODE, 8'hc5);
    wr(sar_adc_pkg::IDX_MODE, 8'h05);
    @(posedge ref_clk);
    chk({converter_power, sar_sample}, 2'b00);
    wr(sar_adc_pkg::IDX_MODE, 8'h80);
    wr(sar_adc_pkg::IDX_REF, 8'h10);
    pwm_enable <= 1'b1;
    wait_s(1'b1);
    wait_s(1'b0);
    repeat (2) @(posedge ref_clk);
    chk(sar_sample, 1'b1);
    pwm_enable <= 1'b0;
    wait_s(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(sar_sample, 1'b0);
    final_report();
  end
endmodule
